// [hdl/memmap_pkg.sv]
// Constants and types for the memory map address decoder
package memmap_pkg;
	// Processor modes, coded as the two mode bits
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_EXPAND = 2'b01,
		MODE_MICRO = 2'b10,
		MODE_UNUSED = 2'b11
	} cpu_mode_t;
	// How the CPU forms the address of an access
	typedef enum logic [1:0] {
		ADDR_FULL = 2'b00,
		ADDR_ZERO_PAGE = 2'b01,
		ADDR_SPECIAL_PAGE = 2'b10,
		ADDR_ILLEGAL = 2'b11
	} addr_kind_t;
	// Target of one access
	typedef enum logic [2:0] {
		TGT_SFR = 3'b000,
		TGT_RAM = 3'b001,
		TGT_ROM = 3'b010,
		TGT_RSVD = 3'b011,
		TGT_EXT = 3'b100,
		TGT_NONE = 3'b101
	} target_t;
	// Address ranges
	localparam logic [15:0] SFR_LAST = 16'h006f;
	localparam logic [15:0] RAM_FIRST = 16'h0070;
	localparam logic [15:0] RAM_LAST = 16'h046f;
	localparam logic [15:0] GAP_FIRST = 16'h0470;
	localparam logic [15:0] GAP_LAST = 16'h7fff;
	localparam logic [15:0] TEST_LO_FIRST = 16'h8000;
	localparam logic [15:0] TEST_LO_LAST = 16'h807f;
	localparam logic [15:0] ROM_FIRST = 16'h8080;
	localparam logic [15:0] ROM_LAST = 16'hfffb;
	localparam logic [15:0] TEST_HI_FIRST = 16'hfffc;
	localparam logic [15:0] BUS_PORT_FIRST = 16'h0008;
	localparam logic [15:0] BUS_PORT_LAST = 16'h000f;
	localparam logic [15:0] MODE_REG_ADDR = 16'h0000;
	// Page upper bytes
	localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
	localparam logic [7:0] SPECIAL_PAGE_HI = 8'hff;
	// Mode bit positions and reset value
	localparam int MODE_BIT_LO = 0;
	localparam int MODE_BIT_HI = 1;
	localparam logic [1:0] MODE_RESET = 2'b00;
endpackage

// [hdl/memory_map_address_decoder.sv]
// Memory map address decoder for the 8-bit CPU address space
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - 0000-006F selects the register area
// - 0070-046F selects internal RAM
// - RAM overlay outside single-chip: read internal, write both
// - 0470-7FFF none single-chip, else external
// - Test areas reserved in single-chip, expansion
// - 8080-FFFB selects internal ROM
// - Microprocessor mode sends ROM range external
// - Lowest 256 addresses flagged as zero page
// - FF00-FFFF flagged as special page
// - Page accesses imply the upper address byte
// - Reset gives single-chip, pin high forces microprocessor
// - Outside single-chip mode: bus port registers go external
module memory_map_address_decoder
	import memmap_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Mode strap pin
	input wire logic boot_mode_select_pin,
	// CPU access request
	input wire logic [15:0] cpu_addr,
	input wire logic [1:0] cpu_addr_kind,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	// Effective address and page flags
	output logic [15:0] eff_addr_q,
	output logic zero_page_q,
	output logic special_page_q,
	// Target selects, one hot
	output logic sel_sfr_q,
	output logic sel_ram_q,
	output logic sel_rom_q,
	output logic sel_rsvd_q,
	output logic sel_ext_q,
	output logic sel_none_q,
	// External bus strobes
	output logic ext_rd_q,
	output logic ext_wr_q,
	// Current processor mode
	output logic [1:0] cpu_mode_control_a_q
);

	// Forms the full address from the addressing kind
	function automatic logic [15:0] form_addr(input logic [1:0] kind,
		input logic [15:0] a);
		unique case (kind)
			ADDR_ZERO_PAGE: form_addr = {ZERO_PAGE_HI, a[7:0]};
			ADDR_SPECIAL_PAGE: form_addr = {SPECIAL_PAGE_HI, a[7:0]};
			default: form_addr = a;
		endcase
	endfunction

	// Range test used by the bus port, RAM, gap, low test area and ROM decodes
	function automatic logic in_range(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Pin synchroniser stages
	logic pin_meta_q;
	logic pin_sync_q;
	// Set on the first clock after reset release; the pin acts at any time
	logic strap_done_q;
	// Mode bits held by the decoder
	logic [1:0] mode_q;
	logic [1:0] mode_d;
	// Combinational decode results
	logic [15:0] addr_d;
	target_t tgt_d;
	logic ext_mode;
	logic micro_mode;
	logic overlay_wr;

	// Two flip-flops on the strap pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= boot_mode_select_pin;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Strap capture flag, set on the first clock after reset release, one clock before the pin is through the synchroniser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
		end
	end

	// Next mode: software write, with the high bit held by the pin
	always_comb begin
		mode_d = mode_q;
		if (cpu_wr && (addr_d == MODE_REG_ADDR)) begin
			mode_d = cpu_wdata[MODE_BIT_HI:MODE_BIT_LO];
		end
		if (pin_sync_q) begin
			mode_d[MODE_BIT_HI] = 1'b1;
		end
	end

	// Mode register, single-chip out of reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= MODE_RESET;
		end else if (!strap_done_q) begin
			// First cycle after release keeps single-chip
			mode_q <= MODE_RESET;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Mode classes; the unused code behaves as microprocessor
	assign micro_mode = mode_q[MODE_BIT_HI];
	assign ext_mode = mode_q != MODE_SINGLE;

	// Page addressing fills in the upper byte
	assign addr_d = form_addr(cpu_addr_kind, cpu_addr);

	// Target decode from address and mode
	always_comb begin
		tgt_d = TGT_NONE;
		if (in_range(addr_d, BUS_PORT_FIRST, BUS_PORT_LAST) && ext_mode) begin
			// Bus port registers lost to the bus
			tgt_d = TGT_EXT;
		end else if (addr_d <= SFR_LAST) begin
			tgt_d = TGT_SFR;
		end else if (in_range(addr_d, RAM_FIRST, RAM_LAST)) begin
			// Internal RAM, reads never go external
			tgt_d = TGT_RAM;
		end else if (in_range(addr_d, GAP_FIRST, GAP_LAST)) begin
			tgt_d = ext_mode ? TGT_EXT : TGT_NONE;
		end else if (in_range(addr_d, TEST_LO_FIRST, TEST_LO_LAST) ||
			(addr_d >= TEST_HI_FIRST)) begin
			// Test areas, external in microprocessor mode
			tgt_d = micro_mode ? TGT_EXT : TGT_RSVD;
		end else if (in_range(addr_d, ROM_FIRST, ROM_LAST)) begin
			tgt_d = micro_mode ? TGT_EXT : TGT_ROM;
		end
	end

	// Writes to overlaid RAM also drive the external bus
	assign overlay_wr = cpu_wr && ext_mode && (tgt_d == TGT_RAM);

	// Registered one-hot selects
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_sfr_q <= 1'b0;
			sel_ram_q <= 1'b0;
			sel_rom_q <= 1'b0;
			sel_rsvd_q <= 1'b0;
			sel_ext_q <= 1'b0;
			sel_none_q <= 1'b1;
		end else begin
			// Exactly one select from the decode
			sel_sfr_q <= tgt_d == TGT_SFR;
			sel_ram_q <= tgt_d == TGT_RAM;
			sel_rom_q <= tgt_d == TGT_ROM;
			sel_rsvd_q <= tgt_d == TGT_RSVD;
			sel_ext_q <= tgt_d == TGT_EXT;
			sel_none_q <= tgt_d == TGT_NONE;
		end
	end

	// Effective address and page flags
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			eff_addr_q <= 16'h0000;
			zero_page_q <= 1'b0;
			special_page_q <= 1'b0;
		end else begin
			eff_addr_q <= addr_d;
			// Zero page is the first 256 bytes
			zero_page_q <= addr_d[15:8] == ZERO_PAGE_HI;
			// Special page is the top 256 bytes
			special_page_q <= addr_d[15:8] == SPECIAL_PAGE_HI;
		end
	end

	// External bus strobes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_rd_q <= 1'b0;
			ext_wr_q <= 1'b0;
		end else begin
			ext_rd_q <= cpu_rd && (tgt_d == TGT_EXT);
			ext_wr_q <= (cpu_wr && (tgt_d == TGT_EXT)) || overlay_wr;
		end
	end

	// Mode output follows the mode register
	assign cpu_mode_control_a_q = mode_q;

	// Checks on the registered decode
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	one_hot_sel_a: assert property ($onehot({sel_sfr_q, sel_ram_q,
		sel_rom_q, sel_rsvd_q, sel_ext_q, sel_none_q}))
		else $error("selects not one hot");
	sfr_range_a: assert property (
		sel_sfr_q |-> (eff_addr_q <= SFR_LAST))
		else $error("register select outside its range");
	ram_range_a: assert property (
		in_range(eff_addr_q, RAM_FIRST, RAM_LAST) |-> sel_ram_q)
		else $error("RAM address not selecting RAM");
	overlay_write_a: assert property ($past(overlay_wr) |->
		(sel_ram_q && ext_wr_q && !ext_rd_q))
		else $error("overlay write not sent to both");
	// Gap in single chip selects none
	gap_single_a: assert property (
		($past(mode_q) == MODE_SINGLE &&
		in_range(eff_addr_q, GAP_FIRST, GAP_LAST)) |-> sel_none_q)
		else $error("gap selected in single-chip mode");
	test_area_a: assert property (
		(!$past(micro_mode) && (eff_addr_q >= TEST_HI_FIRST)) |->
		sel_rsvd_q)
		else $error("test area not reserved");
	rom_micro_a: assert property (
		($past(micro_mode) && in_range(eff_addr_q, ROM_FIRST, ROM_LAST))
		|-> (sel_ext_q && !sel_rom_q))
		else $error("ROM not redirected in microprocessor mode");
	special_page_a: assert property (
		special_page_q == (eff_addr_q >= {SPECIAL_PAGE_HI, 8'h00}))
		else $error("special page flag wrong");
	strap_force_a: assert property (
		(pin_sync_q && strap_done_q) |=> mode_q[MODE_BIT_HI])
		else $error("pin high did not force microprocessor");
	bus_port_a: assert property (
		($past(mode_q) == MODE_EXPAND &&
		in_range(eff_addr_q, BUS_PORT_FIRST, BUS_PORT_LAST)) |-> sel_ext_q)
		else $error("bus port register not external");

	// Scenario coverage
	cover_overlay_c: cover property (overlay_wr ##1 ext_wr_q);
	cover_rom_ext_c: cover property (micro_mode && tgt_d == TGT_EXT);
	cover_page_c: cover property (cpu_addr_kind == ADDR_SPECIAL_PAGE);

endmodule

`default_nettype wire

// [tb/ext_mem_model.sv]
// External memory side model counting bus strobes
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// External bus strobes
	input wire logic ext_rd,
	input wire logic ext_wr,
	// Strobe counts
	output logic [7:0] rd_cnt_q,
	output logic [7:0] wr_cnt_q
);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_cnt_q <= 8'h00;
			wr_cnt_q <= 8'h00;
		end else begin
			rd_cnt_q <= rd_cnt_q + {7'h00, ext_rd};
			wr_cnt_q <= wr_cnt_q + {7'h00, ext_wr};
		end
	end
endmodule
`default_nettype wire

// [tb/tb_memory_map_address_decoder.sv]
// Testbench for the memory map address decoder
`timescale 1ns/100ps
`default_nettype none
module tb_memory_map_address_decoder;
	import memmap_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, pin = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [15:0] addr = 16'h0000, eff;
	logic [1:0] kind = 2'b00, mode;
	logic [7:0] wdata = 8'h00, rd_cnt, wr_cnt;
	logic zp, sp, s_sfr, s_ram, s_rom, s_rsvd, s_ext, s_none, erd, ewr;
	int failures = 0, comparisons = 0, cycles = 0;
	// Single-chip map probe points and targets
	localparam logic [15:0] SA [12] = '{16'h006f, 16'h0070, 16'h00ff,
		16'h046f, 16'h0470, 16'h7fff, 16'h8000, 16'h807f, 16'h8080,
		16'hfffb, 16'hfffc, 16'hff00};
	localparam target_t ST [12] = '{TGT_SFR, TGT_RAM, TGT_RAM, TGT_RAM,
		TGT_NONE, TGT_NONE, TGT_RSVD, TGT_RSVD, TGT_ROM, TGT_ROM,
		TGT_RSVD, TGT_ROM};
	memory_map_address_decoder memory_map_address_decoder_i (.clk(clk),
		.nrst(nrst), .boot_mode_select_pin(pin), .cpu_addr(addr),
		.cpu_addr_kind(kind), .cpu_rd(rd), .cpu_wr(wr), .cpu_wdata(wdata),
		.eff_addr_q(eff), .zero_page_q(zp), .special_page_q(sp),
		.sel_sfr_q(s_sfr), .sel_ram_q(s_ram), .sel_rom_q(s_rom),
		.sel_rsvd_q(s_rsvd), .sel_ext_q(s_ext), .sel_none_q(s_none),
		.ext_rd_q(erd), .ext_wr_q(ewr), .cpu_mode_control_a_q(mode));
	ext_mem_model ext_mem_model_i (.clk(clk), .nrst(nrst), .ext_rd(erd),
		.ext_wr(ewr), .rd_cnt_q(rd_cnt), .wr_cnt_q(wr_cnt));
	// Clock at 200 MHz
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Compare and count
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Counts and verdict
	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// One access, judged one cycle later
	task automatic acc(input logic [15:0] a, input logic [1:0] k,
		input logic r, input logic w, input logic [7:0] d, input target_t t,
		input logic er, input logic ew);
		logic [15:0] e;
		e = (k == 2'b01) ? {8'h00, a[7:0]} :
			(k == 2'b10) ? {8'hff, a[7:0]} : a;
		@(posedge clk);
		addr <= a;
		kind <= k;
		rd <= r;
		wr <= w;
		wdata <= d;
		@(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		#1;
		check("sel", {10'h000, s_sfr, s_ram, s_rom, s_rsvd, s_ext, s_none},
			{10'h000, 6'(6'b100000 >> t)});
		check("ext", {14'h0000, erd, ewr}, {14'h0000, er, ew});
		check("eff", eff, e);
		check("pages", {14'h0000, zp, sp},
			{14'h0000, e[15:8] == 8'h00, e[15:8] == 8'hff});
	endtask
	// Reset defaults
	task automatic t_reset();
		repeat (3) @(posedge clk);
		#1;
		check("mode", {14'h0000, mode}, 16'h0000);
		check("none", {15'h0000, s_none}, 16'h0001);
		$display("test reset done");
	endtask
	// Whole map in single-chip mode, then one zero page and one special page access
	task automatic t_single();
		for (int i = 0; i < 12; i++) begin
			acc(SA[i], 2'b00, 1'b1, 1'b0, 8'h00, ST[i], 1'b0, 1'b0);
		end
		acc(16'h1234, 2'b01, 1'b1, 1'b0, 8'h00, TGT_SFR, 1'b0, 1'b0);
		acc(16'h0012, 2'b10, 1'b1, 1'b0, 8'h00, TGT_ROM, 1'b0, 1'b0);
		$display("test single done");
	endtask
	// Expansion mode: overlay, gap, bus ports
	task automatic t_expand();
		acc(16'h0000, 2'b00, 1'b0, 1'b1, 8'h01, TGT_SFR, 1'b0, 1'b0);
		check("mode", {14'h0000, mode}, 16'h0001);
		acc(16'h0470, 2'b00, 1'b1, 1'b0, 8'h00, TGT_EXT, 1'b1, 1'b0);
		acc(16'h0100, 2'b00, 1'b0, 1'b1, 8'h5a, TGT_RAM, 1'b0, 1'b1);
		acc(16'h0100, 2'b00, 1'b1, 1'b0, 8'h00, TGT_RAM, 1'b0, 1'b0);
		acc(16'h0008, 2'b00, 1'b1, 1'b0, 8'h00, TGT_EXT, 1'b1, 1'b0);
		acc(16'h807f, 2'b00, 1'b1, 1'b0, 8'h00, TGT_RSVD, 1'b0, 1'b0);
		acc(16'h8080, 2'b00, 1'b1, 1'b0, 8'h00, TGT_ROM, 1'b0, 1'b0);
		check("counts", {rd_cnt, wr_cnt}, 16'h0201);
		$display("test expand done");
	endtask
	// Microprocessor mode sends ROM range out
	task automatic t_micro();
		acc(16'h0000, 2'b00, 1'b0, 1'b1, 8'h02, TGT_SFR, 1'b0, 1'b0);
		check("mode", {14'h0000, mode}, 16'h0002);
		acc(16'hfffb, 2'b00, 1'b1, 1'b0, 8'h00, TGT_EXT, 1'b1, 1'b0);
		acc(16'h046f, 2'b00, 1'b1, 1'b0, 8'h00, TGT_RAM, 1'b0, 1'b0);
		$display("test micro done");
	endtask
	// Strap pin forces and holds the upper mode bit
	task automatic t_strap();
		acc(16'h0000, 2'b00, 1'b0, 1'b1, 8'h00, TGT_SFR, 1'b0, 1'b0);
		check("mode", {14'h0000, mode}, 16'h0000);
		@(posedge clk);
		pin <= 1'b1;
		repeat (4) @(posedge clk);
		acc(16'h0000, 2'b00, 1'b0, 1'b1, 8'h00, TGT_SFR, 1'b0, 1'b0);
		check("mode", {14'h0000, mode}, 16'h0002);
		$display("test strap done");
	endtask
	// Pin still high through a second reset boots microprocessor mode
	task automatic t_boot();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check("rst", {13'h0000, mode, s_none}, 16'h0001);
		repeat (2) @(posedge clk);
		#1;
		check("boot", {14'h0000, mode}, 16'h0000);
		repeat (2) @(posedge clk);
		#1;
		check("boot", {14'h0000, mode}, 16'h0002);
		acc(16'h000f, 2'b00, 1'b0, 1'b1, 8'h00, TGT_EXT, 1'b0, 1'b1);
		acc(16'h0200, 2'b00, 1'b0, 1'b1, 8'h33, TGT_RAM, 1'b0, 1'b1);
		acc(16'h0000, 2'b00, 1'b0, 1'b1, 8'h03, TGT_SFR, 1'b0, 1'b0);
		check("mode", {14'h0000, mode}, 16'h0003);
		acc(16'h9000, 2'b11, 1'b1, 1'b0, 8'h00, TGT_EXT, 1'b1, 1'b0);
		acc(16'h00fc, 2'b10, 1'b1, 1'b0, 8'h00, TGT_EXT, 1'b1, 1'b0);
		@(posedge clk);
		#1;
		check("counts", {rd_cnt, wr_cnt}, 16'h0202);
		$display("test boot done");
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			finish_test();
		end
	end
	// Main sequence
	initial begin
		t_reset();
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_single();
		t_expand();
		t_micro();
		t_strap();
		t_boot();
		finish_test();
	end
endmodule
`default_nettype wire
